// ==== inc/dma_wem_params.svh ====
`ifndef DMA_WEM_PARAMS_SVH
`define DMA_WEM_PARAMS_SVH
// Register block base and offsets
`define DMA_BASE_ADDR 32'ha000_0000
`define DMA_STATUS_OFS 12'h000
`define DMA_CLEAR_OFS 12'h004
`define DMA_SETUP_OFS 12'h008
`define DMA_SETUP_STRIDE 12'h014
`define DMA_COUNT_OFS 12'h00c
`define DMA_PADDR_OFS 12'h010
`define DMA_MADDR_OFS 12'h018
`define DMA_REQSEL_OFS 12'h100
`define DMA_REGION_MASK 32'hffff_f000
// Per-channel flag positions inside the status word
`define FLAG_ANY 0
`define FLAG_FULL 1
`define FLAG_HALF 2
`define FLAG_ERR 3
// Setup register fields
`define SET_EN 0
`define SET_FULL_IE 1
`define SET_HALF_IE 2
`define SET_ERR_IE 3
`define SET_DIR 4
`define SET_PERIPH_ADDR_INCREMENT 6
`define SET_MEM_ADDR_INCREMENT 7
`define SET_PERIPH_ITEM_WIDTH 8
`define SET_MEM_ITEM_WIDTH 10
`define STATUS_RST 32'h0000_0000
// AHB size codes
`define HSIZE_BYTE 3'h0
`define HSIZE_HALF 3'h1
`define HSIZE_WORD 3'h2
`endif

// ==== inc/dma_wem_pkg.sv ====
`default_nettype none
package dma_wem_pkg;
	// Master-side AHB request
	typedef struct packed {
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
	} ahb_req_t;
	// Slave-side AHB request
	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
	} ahb_slv_t;
	typedef enum logic [1:0] {W8, W16, W32, WRSV} width_t;
	typedef enum {ST_IDLE, ST_RA, ST_RD, ST_WA, ST_WD} xfer_state_t;
endpackage
`default_nettype wire

// ==== rtl/dma_wem_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
// Plain synchronous FIFO; honest full and empty
module dma_wem_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wp_q, rp_q;
	logic push, pop;
	// Pointer wrap relies on a power-of-two depth
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("fifo depth must be a power of two");
	end
	assign o_in_ready = (wp_q - rp_q) != (AW+1)'(DEPTH);
	assign o_out_valid = wp_q != rp_q;
	assign o_out_data = mem[rp_q[AW-1:0]];
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;
	// Storage has no reset; only pointers matter
	always_ff @(posedge i_clk) begin
		if (push)
			mem[wp_q[AW-1:0]] <= i_in_data;
	end
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			if (push)
				wp_q <= wp_q + 1'b1;
			if (pop)
				rp_q <= rp_q + 1'b1;
		end
	end
endmodule // dma_wem_fifo
`default_nettype wire

// ==== rtl/dma_wem_top.sv ====
// Summary of operation
// RULE_01: 16-bit to 32-bit: zero-extend halfword; source steps 2, destination 4.
// RULE_02: 32-bit to 8-bit: read words, write low byte to consecutive bytes.
// RULE_03: 32-bit to 16-bit: read words, write lower halfword, destination steps 2.
// RULE_04: Equal 32-bit widths copy whole words, both addresses step four.
// RULE_05: Register port accepts word accesses only; narrower ones get an error.
// RULE_06: Narrow writes replicate data across all lanes with true HSIZE.
// RULE_07: A size-blind bridge turns a byte write into a replicated word.
// RULE_08: Such a bridge turns a halfword write into a doubled word.
// RULE_09: Channel access to reserved space counts as transfer error.
// RULE_10: A transfer error clears the channel enable bit in hardware.
// RULE_11: Error sets the channel error flag; interrupt only if enabled.
// RULE_12: Half, complete and error events each have flag and enable.
// RULE_13: Eight peripheral requests are multiplexed with the ADC request.
// RULE_14: A shared register bit per channel picks peripheral or ADC request.
// RULE_15: Register block at 0xa0000000; status at 0, clear at 4.
// RULE_16: Status read-only, clear write-only, both reset to zero.
// RULE_17: Flags set by hardware, cleared by writing one to clear register.
// RULE_18: Per-channel any-event flag set on error, half or complete.
// RULE_19: Four status bits per channel: any, complete, half, error.
// RULE_20: Half event at half the programmed count, complete at zero.
`timescale 1ns/1ps
`default_nettype none
`include "dma_wem_params.svh"
module dma_wem_top #(
	parameter int NCH = 8,
	parameter int FIFO_DEPTH = 32
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire dma_wem_pkg::ahb_slv_t i_slv,
	output logic [31:0] o_slv_hrdata,
	output logic o_slv_hready,
	output logic o_slv_hresp,
	output dma_wem_pkg::ahb_req_t o_mst,
	input wire logic [31:0] i_mst_hrdata,
	input wire logic i_mst_hready,
	input wire logic i_mst_hresp,
	input wire logic [NCH-1:0] i_periph_req,
	input wire logic i_adc_req,
	output logic [NCH-1:0] o_irq
);
	import dma_wem_pkg::*;
	// The channel index register is three bits wide
	if (NCH < 1 || NCH > 8) begin : g_bad_nch
		$error("channel count must be 1..8");
	end
	logic [31:0] setup_q [NCH];
	logic [15:0] count_q [NCH];
	logic [15:0] count0_q [NCH];
	logic [31:0] paddr_q [NCH];
	logic [31:0] maddr_q [NCH];
	logic [NCH-1:0] reqsel_q;
	logic [31:0] status_q;
	logic [NCH-1:0] req_s1_q, req_s2_q, req_pick;
	logic adc_s1_q, adc_s2_q;
	logic [NCH-1:0] ev_full, ev_half, ev_err, en_clr;

	// Byte count of a width code
	function automatic logic [31:0] step_of(input logic [1:0] w);
		case (w)
			2'd0: step_of = 32'h1;
			2'd1: step_of = 32'h2;
			default: step_of = 32'h4;
		endcase
	endfunction
	// Lane replication for narrow writes
	function automatic logic [31:0] lanes(input logic [1:0] w,
		input logic [31:0] d);
		case (w)
			2'd0: lanes = {4{d[7:0]}}; // [RULE_06] [RULE_07]
			2'd1: lanes = {2{d[15:0]}}; // [RULE_06] [RULE_08]
			default: lanes = d; // [RULE_04]
		endcase
	endfunction
	// Only the top sixteenth of the map (top nibble 0xf) is reserved
	function automatic logic reserved(input logic [31:0] a);
		reserved = a[31:28] == 4'hf;
	endfunction

	// Two-flop synchronisers first; the mux reads settled copies only
	always_ff @(posedge i_clk) begin
		req_s1_q <= i_periph_req;
		req_s2_q <= req_s1_q;
		adc_s1_q <= i_adc_req;
		adc_s2_q <= adc_s1_q;
	end
	// Per-channel pick of peripheral or converter request
	always_comb begin
		for (int c = 0; c < NCH; c++)
			req_pick[c] = reqsel_q[c] ? adc_s2_q : req_s2_q[c]; // [RULE_13] [RULE_14]
	end

	// ---- Slave port: address phase captured, data phase applied
	logic aph_q, aph_wr_q, aph_bad_q, err2_q;
	logic [11:0] aph_ofs_q;
	logic slv_ok, in_blk;
	assign in_blk = (i_slv.haddr & `DMA_REGION_MASK) == `DMA_BASE_ADDR; // [RULE_15]
	assign slv_ok = i_slv.hsel && i_slv.htrans[1] && in_blk && o_slv_hready;
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			aph_q <= 1'b0;
			aph_wr_q <= 1'b0;
			aph_bad_q <= 1'b0;
			aph_ofs_q <= '0;
			err2_q <= 1'b0;
			o_slv_hready <= 1'b1;
			o_slv_hresp <= 1'b0;
		end else begin
			aph_q <= slv_ok && i_slv.hsize == `HSIZE_WORD;
			aph_wr_q <= i_slv.hwrite;
			aph_ofs_q <= i_slv.haddr[11:0];
			aph_bad_q <= slv_ok && i_slv.hsize != `HSIZE_WORD; // [RULE_05]
			// Two-cycle ERROR answer as AHB demands
			if (aph_bad_q) begin
				o_slv_hresp <= 1'b1;
				o_slv_hready <= 1'b0;
				err2_q <= 1'b1;
			end else if (err2_q) begin
				o_slv_hready <= 1'b1;
				err2_q <= 1'b0;
			end else begin
				o_slv_hresp <= 1'b0;
				o_slv_hready <= 1'b1;
			end
		end
	end
	logic wr_now;
	logic [31:0] clr_mask;
	assign wr_now = aph_q && aph_wr_q;
	assign clr_mask = (wr_now && aph_ofs_q == `DMA_CLEAR_OFS) ?
		i_slv.hwdata : 32'h0;
	// Read data: clear register is write-only and reads zero
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_slv_hrdata <= '0;
		end else if (slv_ok && !i_slv.hwrite) begin
			o_slv_hrdata <= 32'h0;
			if (i_slv.haddr[11:0] == `DMA_STATUS_OFS)
				o_slv_hrdata <= status_q; // [RULE_16]
			if (i_slv.haddr[11:0] == `DMA_REQSEL_OFS)
				o_slv_hrdata <= 32'(reqsel_q);
			for (int c = 0; c < NCH; c++) begin
				if (i_slv.haddr[11:0] == `DMA_SETUP_OFS + 12'(c) * `DMA_SETUP_STRIDE)
					o_slv_hrdata <= setup_q[c];
				if (i_slv.haddr[11:0] == `DMA_COUNT_OFS + 12'(c) * `DMA_SETUP_STRIDE)
					o_slv_hrdata <= {16'h0, count_q[c]};
			end
		end
	end

	// Status flags: hardware set wins over software clear
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			status_q <= `STATUS_RST; // [RULE_16]
		end else begin
			for (int c = 0; c < NCH; c++) begin
				status_q[4*c+`FLAG_FULL] <= ev_full[c] |
					(status_q[4*c+`FLAG_FULL] & ~clr_mask[4*c+`FLAG_FULL]); // [RULE_17] [RULE_19]
				status_q[4*c+`FLAG_HALF] <= ev_half[c] |
					(status_q[4*c+`FLAG_HALF] & ~clr_mask[4*c+`FLAG_HALF]); // [RULE_12]
				status_q[4*c+`FLAG_ERR] <= ev_err[c] |
					(status_q[4*c+`FLAG_ERR] & ~clr_mask[4*c+`FLAG_ERR]); // [RULE_11]
				status_q[4*c+`FLAG_ANY] <= ev_full[c] | ev_half[c] | ev_err[c] |
					(status_q[4*c+`FLAG_ANY] & ~clr_mask[4*c+`FLAG_ANY]); // [RULE_18]
			end
		end
	end

	// Interrupt per channel gated by its enables
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_irq <= '0;
		end else begin
			for (int c = 0; c < NCH; c++) begin
				o_irq[c] <= (status_q[4*c+`FLAG_FULL] & setup_q[c][`SET_FULL_IE]) |
					(status_q[4*c+`FLAG_HALF] & setup_q[c][`SET_HALF_IE]) |
					(status_q[4*c+`FLAG_ERR] & setup_q[c][`SET_ERR_IE]); // [RULE_11] [RULE_12]
			end
		end
	end

	// ---- Transfer engine, one channel served at a time
	xfer_state_t st_q;
	logic [2:0] ch_q;
	logic [31:0] rd_addr, wr_addr;
	logic [1:0] rd_w, wr_w;
	logic dir;
	logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
	logic [31:0] f_out_data, f_in_data;
	assign dir = setup_q[ch_q][`SET_DIR];
	assign rd_addr = dir ? maddr_q[ch_q] : paddr_q[ch_q];
	assign wr_addr = dir ? paddr_q[ch_q] : maddr_q[ch_q];
	assign rd_w = dir ? setup_q[ch_q][`SET_MEM_ITEM_WIDTH+:2] : setup_q[ch_q][`SET_PERIPH_ITEM_WIDTH+:2];
	assign wr_w = dir ? setup_q[ch_q][`SET_PERIPH_ITEM_WIDTH+:2] : setup_q[ch_q][`SET_MEM_ITEM_WIDTH+:2];
	// Read data trimmed to source width; zero-extends for narrow sources
	always_comb begin
		case (rd_w)
			2'd0: f_in_data = {24'h0, i_mst_hrdata[8*rd_addr[1:0]+:8]};
			2'd1: f_in_data = {16'h0, i_mst_hrdata[16*rd_addr[1]+:16]}; // [RULE_01]
			default: f_in_data = i_mst_hrdata; // [RULE_02] [RULE_03]
		endcase
	end
	assign f_in_valid = st_q == ST_RD && i_mst_hready && !i_mst_hresp;
	assign f_out_ready = st_q == ST_WA;

	dma_wem_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_in_valid(f_in_valid),
		.o_in_ready(f_in_ready),
		.i_in_data(f_in_data),
		.o_out_valid(f_out_valid),
		.i_out_ready(f_out_ready),
		.o_out_data(f_out_data)
	);

	// Sequencer: read item, buffer it, write item
	always_ff @(posedge i_clk) begin
		// Strobes default low, so reset never leaves them unknown
		ev_full <= '0;
		ev_half <= '0;
		ev_err <= '0;
		en_clr <= '0;
		if (i_sys_rst) begin
			st_q <= ST_IDLE;
			ch_q <= '0;
			o_mst <= '0;
		end else begin
			case (st_q)
				ST_IDLE: begin
					o_mst.htrans <= 2'b00;
					ch_q <= (ch_q == 3'(NCH-1)) ? 3'h0 : ch_q + 3'h1;
					if (setup_q[ch_q][`SET_EN] && req_pick[ch_q] && count_q[ch_q] != 0
						&& f_in_ready) begin // Buffer back-pressure stalls reads
						if (reserved(rd_addr)) begin
							ev_err[ch_q] <= 1'b1; // [RULE_09]
							en_clr[ch_q] <= 1'b1; // [RULE_10]
						end else begin
							ch_q <= ch_q;
							o_mst.haddr <= rd_addr;
							o_mst.hwrite <= 1'b0;
							o_mst.hsize <= {1'b0, rd_w};
							o_mst.htrans <= 2'b10;
							st_q <= ST_RA;
						end
					end
				end
				ST_RA: if (i_mst_hready) begin
					o_mst.htrans <= 2'b00;
					st_q <= ST_RD;
				end
				ST_RD: if (i_mst_hready) begin
					if (i_mst_hresp) begin
						ev_err[ch_q] <= 1'b1; // [RULE_10] [RULE_11]
						en_clr[ch_q] <= 1'b1;
						st_q <= ST_IDLE;
					end else begin
						st_q <= ST_WA;
					end
				end
				ST_WA: if (f_out_valid) begin
					if (reserved(wr_addr)) begin
						ev_err[ch_q] <= 1'b1; // [RULE_09]
						en_clr[ch_q] <= 1'b1;
						st_q <= ST_IDLE;
					end else begin
						o_mst.haddr <= wr_addr;
						o_mst.hwrite <= 1'b1;
						o_mst.hsize <= {1'b0, wr_w}; // [RULE_06]
						o_mst.hwdata <= lanes(wr_w, f_out_data); // [RULE_02] [RULE_03]
						o_mst.htrans <= 2'b10;
						st_q <= ST_WD;
					end
				end
				ST_WD: if (i_mst_hready && o_mst.htrans != 2'b00) begin
					o_mst.htrans <= 2'b00;
				end else if (i_mst_hready) begin
					st_q <= ST_IDLE;
					if (i_mst_hresp) begin
						ev_err[ch_q] <= 1'b1;
						en_clr[ch_q] <= 1'b1; // [RULE_10]
					end else begin
						if (count_q[ch_q] == 16'h1)
							ev_full[ch_q] <= 1'b1; // [RULE_20]
						if (count_q[ch_q] - 16'h1 == count0_q[ch_q] >> 1)
							ev_half[ch_q] <= 1'b1; // [RULE_20]
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// Channel registers: software writes, hardware clears enable and steps
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			reqsel_q <= '0;
			for (int c = 0; c < NCH; c++) begin
				setup_q[c] <= '0;
				count_q[c] <= '0;
				count0_q[c] <= '0;
				paddr_q[c] <= '0;
				maddr_q[c] <= '0;
			end
		end else begin
			if (wr_now && aph_ofs_q == `DMA_REQSEL_OFS)
				reqsel_q <= i_slv.hwdata[NCH-1:0]; // [RULE_14]
			for (int c = 0; c < NCH; c++) begin
				if (wr_now && aph_ofs_q == `DMA_SETUP_OFS + 12'(c) * `DMA_SETUP_STRIDE)
					setup_q[c] <= i_slv.hwdata;
				if (wr_now && aph_ofs_q == `DMA_COUNT_OFS + 12'(c) * `DMA_SETUP_STRIDE) begin
					count_q[c] <= i_slv.hwdata[15:0];
					count0_q[c] <= i_slv.hwdata[15:0];
				end
				if (wr_now && aph_ofs_q == `DMA_PADDR_OFS + 12'(c) * `DMA_SETUP_STRIDE)
					paddr_q[c] <= i_slv.hwdata;
				if (wr_now && aph_ofs_q == `DMA_MADDR_OFS + 12'(c) * `DMA_SETUP_STRIDE)
					maddr_q[c] <= i_slv.hwdata;
				if (en_clr[c])
					setup_q[c][`SET_EN] <= 1'b0; // [RULE_10]
				// Item done: each side with its increment bit set steps by its own width
				if (st_q == ST_WD && o_mst.htrans == 2'b00 && i_mst_hready
					&& !i_mst_hresp && ch_q == 3'(c)) begin
					count_q[c] <= count_q[c] - 16'h1;
					if (setup_q[c][`SET_PERIPH_ADDR_INCREMENT])
						paddr_q[c] <= paddr_q[c] + step_of(setup_q[c][`SET_PERIPH_ITEM_WIDTH+:2]); // [RULE_01]
					if (setup_q[c][`SET_MEM_ADDR_INCREMENT])
						maddr_q[c] <= maddr_q[c] + step_of(setup_q[c][`SET_MEM_ITEM_WIDTH+:2]); // [RULE_04]
				end
			end
		end
	end
endmodule // dma_wem_top
`default_nettype wire

// ==== testbench/dma_wem_props.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dma_wem_params.svh"
module dma_wem_props #(
	parameter int NCH = 8,
	parameter int FIFO_DEPTH = 32
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire dma_wem_pkg::ahb_slv_t i_slv,
	input wire logic [31:0] o_slv_hrdata,
	input wire logic o_slv_hready,
	input wire logic o_slv_hresp,
	input wire dma_wem_pkg::ahb_req_t o_mst,
	input wire logic [31:0] i_mst_hrdata,
	input wire logic i_mst_hready,
	input wire logic i_mst_hresp,
	input wire logic [NCH-1:0] i_periph_req,
	input wire logic i_adc_req,
	input wire logic [NCH-1:0] o_irq
);
	import dma_wem_pkg::*;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	// Register access taken, master write address phase taken
	wire logic tk = i_slv.hsel && i_slv.htrans[1] && o_slv_hready;
	wire logic mw = o_mst.htrans[1] && o_mst.hwrite && i_mst_hready;
	property p_narrow_err;
		tk && i_slv.hsize != `HSIZE_WORD |-> ##[1:2]
			(o_slv_hresp && !o_slv_hready) ##1 (o_slv_hresp && o_slv_hready);
	endproperty
	a_narrow_err: assert property (p_narrow_err)
		else $error("narrow register access not refused");
	property p_word_ok;
		tk && i_slv.hsize == `HSIZE_WORD |=> o_slv_hready && !o_slv_hresp;
	endproperty
	a_word_ok: assert property (p_word_ok)
		else $error("word register access refused");
	property p_byte_rep;
		mw && o_mst.hsize == `HSIZE_BYTE |=>
			o_mst.hwdata == {4{o_mst.hwdata[7:0]}};
	endproperty
	a_byte_rep: assert property (p_byte_rep)
		else $error("byte write not replicated");
	property p_half_rep;
		mw && o_mst.hsize == `HSIZE_HALF |=>
			o_mst.hwdata == {2{o_mst.hwdata[15:0]}};
	endproperty
	a_half_rep: assert property (p_half_rep)
		else $error("halfword write not replicated");
	property p_size;
		o_mst.htrans[1] |-> o_mst.hsize <= `HSIZE_WORD;
	endproperty
	a_size: assert property (p_size)
		else $error("master size code out of range");
	// Single transfers only, never a burst continuation
	property p_no_seq;
		o_mst.htrans[1] |-> !o_mst.htrans[0];
	endproperty
	a_no_seq: assert property (p_no_seq)
		else $error("master issued sequential transfer");
	property p_hold;
		o_mst.htrans[1] && !i_mst_hready && !i_mst_hresp |=>
			$stable(o_mst.haddr) && $stable(o_mst.hsize);
	endproperty
	a_hold: assert property (p_hold)
		else $error("master address changed while stalled");
	// Reserved space is refused before any bus cycle is started
	property p_rsv;
		o_mst.htrans[1] |-> o_mst.haddr[31:28] != 4'hf;
	endproperty
	a_rsv: assert property (p_rsv)
		else $error("master access issued to reserved space");
	c_narrow: cover property (tk && i_slv.hsize != `HSIZE_WORD);
	c_byte: cover property (mw && o_mst.hsize == `HSIZE_BYTE);
	c_irq: cover property ($rose(|o_irq));
endmodule // dma_wem_props
bind dma_wem_top dma_wem_props #(.NCH(NCH), .FIFO_DEPTH(FIFO_DEPTH))
	dma_wem_props_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_slv(i_slv),
	.o_slv_hrdata(o_slv_hrdata), .o_slv_hready(o_slv_hready),
	.o_slv_hresp(o_slv_hresp), .o_mst(o_mst), .i_mst_hrdata(i_mst_hrdata),
	.i_mst_hready(i_mst_hready), .i_mst_hresp(i_mst_hresp),
	.i_periph_req(i_periph_req), .i_adc_req(i_adc_req), .o_irq(o_irq));
`default_nettype wire

// ==== testbench/dma_ahb_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
module dma_ahb_mem (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire dma_wem_pkg::ahb_req_t i_req,
	input wire logic [3:0] i_wait,
	output logic [31:0] o_hrdata,
	output logic o_hready,
	output logic o_hresp
);
	import dma_wem_pkg::*;
	logic [31:0] mem_q [256];
	ahb_req_t ph_q;
	logic act_q;
	logic [3:0] cnt_q;
	// One data phase at a time; the top two regions answer a two-cycle error
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			act_q <= 1'b0;
			o_hready <= 1'b1;
			o_hresp <= 1'b0;
			o_hrdata <= 32'h0;
		end else if (o_hready) begin
			// Size ignored: the whole bus lands on the aligned word
			if (act_q && ph_q.hwrite && !o_hresp)
				mem_q[ph_q.haddr[9:2]] <= i_req.hwdata;
			act_q <= i_req.htrans[1];
			ph_q <= i_req;
			cnt_q <= i_wait;
			o_hresp <= i_req.htrans[1] && i_req.haddr[31:29] == 3'h7;
			o_hready <= !i_req.htrans[1] ||
				(i_req.haddr[31:29] != 3'h7 && i_wait == 4'h0);
			o_hrdata <= i_wait == 4'h0 ? mem_q[i_req.haddr[9:2]] : ~o_hrdata;
		end else if (o_hresp || cnt_q == 4'h1) begin
			o_hready <= 1'b1;
			o_hrdata <= mem_q[ph_q.haddr[9:2]];
		end else begin
			// Garbage on the data lines until ready
			cnt_q <= cnt_q - 4'h1;
			o_hrdata <= ~o_hrdata;
		end
	end
endmodule // dma_ahb_mem
`default_nettype wire

// ==== testbench/dma_width_error_irq_mux_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dma_wem_params.svh"
module dma_width_error_irq_mux_tb;
	import dma_wem_pkg::*;
	localparam logic [1:0] PS[5] = '{2'h1, 2'h2, 2'h2, 2'h2, 2'h0};
	localparam logic [1:0] MS[5] = '{2'h2, 2'h0, 2'h1, 2'h2, 2'h0};
	logic i_clk = 0, i_sys_rst = 1, i_adc_req = 0, i_mst_hready, i_mst_hresp;
	ahb_slv_t i_slv = '0;
	ahb_req_t o_mst;
	logic [31:0] o_slv_hrdata, i_mst_hrdata, rd, sa, rs = 32'h4e1f9e12;
	logic o_slv_hready, o_slv_hresp, er, dph_q = 0;
	logic [7:0] i_periph_req = '0, o_irq;
	logic [3:0] mw = '0;
	logic [14:0] ph_q;
	logic [46:0] wq[$];
	int err_count = 0, compares = 0, i, k;
	always #2.5 i_clk = ~i_clk;
	dma_wem_top dma_wem_top_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_slv(i_slv), .o_slv_hrdata(o_slv_hrdata), .o_slv_hready(o_slv_hready),
		.o_slv_hresp(o_slv_hresp), .o_mst(o_mst), .i_mst_hrdata(i_mst_hrdata),
		.i_mst_hready(i_mst_hready), .i_mst_hresp(i_mst_hresp),
		.i_periph_req(i_periph_req), .i_adc_req(i_adc_req), .o_irq(o_irq));
	dma_ahb_mem dma_ahb_mem_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_req(o_mst), .i_wait(mw), .o_hrdata(i_mst_hrdata),
		.o_hready(i_mst_hready), .o_hresp(i_mst_hresp));
	function automatic logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	// Expected write: size, low address bits, lane-replicated data
	function automatic logic [46:0] ew(logic [1:0] p, m, int k, logic [31:0] v);
		v = p == 2'h0 ? v & 32'hff : (p == 2'h1 ? v & 32'hffff : v);
		v = m == 2'h0 ? {4{v[7:0]}} : (m == 2'h1 ? {2{v[15:0]}} : v);
		return {1'b0, m, 12'h200 + 12'(k << m), v};
	endfunction
	task automatic check(string n, logic [46:0] s, logic [46:0] e);
		compares++;
		if (s !== e) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic close_out();
		if (err_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// One register access; data phase follows the address phase
	task automatic bus(logic w, logic [2:0] z, logic [11:0] a, logic [31:0] d);
		int n;
		@(posedge i_clk);
		#1 i_slv = '{1'b1, `DMA_BASE_ADDR | a, 2'b10, w, z, 32'h0};
		@(posedge i_clk);
		#1 i_slv = '{1'b0, 32'h0, 2'b00, 1'b0, 3'h0, d};
		er = 0;
		n = 0;
		do begin
			@(posedge i_clk);
			#1;
			er |= o_slv_hresp;
			n++;
		end while (!(o_slv_hready && (z == `HSIZE_WORD || er)) && n < 4);
		rd = o_slv_hrdata;
	endtask
	task automatic rchk(string n, logic [11:0] a, logic [31:0] e);
		bus(0, `HSIZE_WORD, a, 32'h0);
		check(n, rd, e);
	endtask
	// Program channel 0, hold its request and wait for its interrupt
	task automatic run(int c, logic [31:0] pa, ma, logic [2:0] ie);
		int n;
		for (n = 0; n < 4; n++)
			dma_ahb_mem_inst.mem_q[pa[9:2] + n] = xs();
		wq.delete();
		// Stop the channel first so old widths never start an item
		bus(1, `HSIZE_WORD, `DMA_SETUP_OFS, 32'h0);
		bus(1, `HSIZE_WORD, `DMA_PADDR_OFS, pa);
		bus(1, `HSIZE_WORD, `DMA_MADDR_OFS, ma);
		bus(1, `HSIZE_WORD, `DMA_COUNT_OFS, 32'h4);
		bus(1, `HSIZE_WORD, `DMA_REQSEL_OFS, {31'h0, c[0]});
		i_adc_req = c[0];
		i_periph_req[0] = !c[0];
		bus(1, `HSIZE_WORD, `DMA_SETUP_OFS,
			{20'h0, MS[c], PS[c], 4'hc, ie, 1'b1});
		for (n = 0; o_irq[0] !== 1'b1 && n < 3000; n++) begin
			@(posedge i_clk);
			#1;
		end
		i_adc_req = 0;
		i_periph_req = '0;
	endtask
	// Record every completed master write
	always @(posedge i_clk) begin
		if (dph_q && i_mst_hready && !i_mst_hresp)
			wq.push_back({ph_q, o_mst.hwdata});
		if (i_mst_hready) begin
			dph_q <= o_mst.htrans[1] && o_mst.hwrite;
			ph_q <= {o_mst.hsize, o_mst.haddr[11:0]};
		end
	end
	// Random wait states from the memory side
	always @(posedge i_clk)
		#1 mw = 4'(xs() & 32'h3);
	initial begin
		#100000;
		err_count++;
		close_out();
	end
	initial begin
		repeat (8) @(posedge i_clk);
		#1 i_sys_rst = 0;
		rchk("status", `DMA_STATUS_OFS, 32'h0);
		rchk("clear", `DMA_CLEAR_OFS, 32'h0);
		for (i = 0; i < 5; i++) begin
			run(i, 32'h100, 32'h200, 3'b001);
			check("writes", 47'(wq.size()), 47'h4);
			for (k = 0; k < 4; k++) begin
				sa = 32'h100 + (k << PS[i]);
				rd = dma_ahb_mem_inst.mem_q[sa[9:2]] >> {sa[1:0], 3'b0};
				check("wr", wq.pop_front(), ew(PS[i], MS[i], k, rd));
			end
			rchk("flags", `DMA_STATUS_OFS, 32'h7);
			check("irq", o_irq[0], 1'b1);
			bus(1, `HSIZE_WORD, `DMA_CLEAR_OFS, 32'hf);
			rchk("cleared", `DMA_STATUS_OFS, 32'h0);
		end
		run(0, 32'h100, 32'hf000_0200, 3'b000);
		rchk("err", `DMA_STATUS_OFS, 32'h9);
		check("irq off", o_irq[0], 1'b0);
		bus(0, `HSIZE_WORD, `DMA_SETUP_OFS, 32'h0);
		check("enable", rd[0], 1'b0);
		bus(1, `HSIZE_WORD, `DMA_CLEAR_OFS, 32'hf);
		run(0, 32'hf000_0100, 32'h200, 3'b100);
		check("irq on", o_irq[0], 1'b1);
		bus(1, `HSIZE_WORD, `DMA_CLEAR_OFS, 32'hf);
		// Destination answers a bus error in the write phase
		run(0, 32'h100, 32'he000_0200, 3'b100);
		rchk("bus err", `DMA_STATUS_OFS, 32'h9);
		bus(0, `HSIZE_WORD, `DMA_SETUP_OFS, 32'h0);
		check("bus err enable", rd[0], 1'b0);
		bus(0, `HSIZE_BYTE, `DMA_STATUS_OFS, 32'h0);
		check("hresp", er, 1'b1);
		bus(1, `HSIZE_HALF, `DMA_CLEAR_OFS, 32'hf);
		bus(1, `HSIZE_WORD, `DMA_STATUS_OFS, 32'h0);
		rchk("kept", `DMA_STATUS_OFS, 32'h9);
		rchk("unmapped", 12'hffc, 32'h0);
		close_out();
	end
endmodule // dma_width_error_irq_mux_tb
`default_nettype wire
